// [hw/stream_merge_router.v]
// Ten-port audio stream merge and distribution router
`timescale 1ns/1ps
`include "stream_merge_consts.vh"
module stream_merge_router #(
  parameter NP  = 10,
  parameter AW  = 24,
  parameter SW  = 8,
  parameter FAW = 4
) (
  // Clock and reset
  input  wire             ref_clk_in,
  input  wire             nrst_in,
  // Network mode from controller, 1 = Manual
  input  wire             manual_mode_in,
  // Local preset button, asynchronous
  input  wire             preset_btn_in,
  // Receive streams, port k at bits k*W
  input  wire [NP-1:0]    rx_valid_in,
  input  wire [NP*AW-1:0] rx_audio_in,
  input  wire [NP*SW-1:0] rx_side_in,
  // Transmit streams
  output reg  [NP-1:0]    tx_valid_out,
  output reg  [NP*AW-1:0] tx_audio_out,
  output reg  [NP*SW-1:0] tx_side_out,
  // Merged stream towards the network buffer
  output wire             mrg_valid_out,
  input  wire             mrg_ready_in,
  output wire [AW-1:0]    mrg_audio_out,
  output wire             mrg_stall_out,
  // Avalon-MM slave
  input  wire [3:0]       avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  output reg  [31:0]      avs_readdata,
  output wire             avs_waitrequest
);
  localparam MASK_ALL  = 10'h03FF;
  localparam MASK_1_9  = 10'h01FF;
  localparam MASK_1_8  = 10'h00FF;
  localparam [15:0] DB_CYC = `BTN_DEBOUNCE_CYC;

  reg  [1:0]    preset_r;
  reg           btn_s1_r;
  reg           btn_s2_r;
  reg           btn_st_r;
  reg  [15:0]   db_cnt_r;
  reg           red_sel_r;
  reg           red_sel_nxt;
  reg           ack_r;
  reg  [9:0]    in_mask;
  reg  [AW-1:0] mrg_audio;
  reg  [SW-1:0] mrg_side;
  reg           mrg_any;
  reg  [AW-1:0] ret_audio;
  reg           ret_valid;
  integer       k;
  integer       i;
  wire          manual;
  wire          press;
  wire [1:0]    eff_preset;
  wire [FAW:0]  fifo_level;
  wire          fifo_in_ready;
  wire          bus_req;

  // Mode comes from the controller pin; software may only mirror it
  assign manual     = manual_mode_in;
  assign eff_preset = manual ? preset_r : `PRESET_A;

  // Button synchroniser, debounce, press edge
  assign press = btn_s2_r & ~btn_st_r & (db_cnt_r == DB_CYC);
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      btn_s1_r <= 1'b0;
      btn_s2_r <= 1'b0;
      btn_st_r <= 1'b0;
      db_cnt_r <= 16'h0000;
    end
    else
    begin
      btn_s1_r <= preset_btn_in;
      btn_s2_r <= btn_s1_r;
      if (btn_s2_r == btn_st_r)
        db_cnt_r <= 16'h0000;
      else if (db_cnt_r != DB_CYC)
        db_cnt_r <= db_cnt_r + 16'h0001;
      else
      begin
        btn_st_r <= btn_s2_r;
        db_cnt_r <= 16'h0000;
      end
    end
  end

  // Preset cycles even in Auto so one is always selected
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      preset_r <= `PRESET_RST;
    else if (press | (bus_req & avs_write & ack_r &
             (avs_address == `ADDR_CTRL) & avs_writedata[`CTRL_ADV_BIT]))
      preset_r <= (preset_r == `PRESET_C) ? `PRESET_A : preset_r + 2'h1;
  end

  // Redundant pair: stay on primary until it drops out
  always @*
  begin
    red_sel_nxt = red_sel_r;
    if (red_sel_r == 1'b0 && !rx_valid_in[8] && rx_valid_in[9])
      red_sel_nxt = 1'b1;
    else if (red_sel_r == 1'b1 && !rx_valid_in[9] && rx_valid_in[8])
      red_sel_nxt = 1'b0;
  end
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      red_sel_r <= 1'b0;
    else
      red_sel_r <= red_sel_nxt;
  end

  // Merge: audio from preset's inputs, side data from all valid ports
  always @*
  begin
    case (eff_preset)
      `PRESET_B: in_mask = MASK_1_9;
      `PRESET_C: in_mask = MASK_1_8;
      default:   in_mask = MASK_ALL;
    endcase
    mrg_audio = {AW{1'b0}};
    mrg_side  = {SW{1'b0}};
    mrg_any   = 1'b0;
    for (i = 0; i < NP; i = i + 1)
    begin
      // Audio only from valid ports in the preset's mask; side data from every valid port
      if (rx_valid_in[i] & in_mask[i])
      begin
        mrg_audio = mrg_audio | rx_audio_in[i*AW +: AW];
        mrg_any   = 1'b1;
      end
      if (rx_valid_in[i])
        mrg_side = mrg_side | rx_side_in[i*SW +: SW];
    end
    if (eff_preset == `PRESET_B)
    begin
      ret_audio = rx_audio_in[9*AW +: AW];
      ret_valid = rx_valid_in[9];
    end
    else
    begin
      ret_audio = red_sel_r ? rx_audio_in[9*AW +: AW] : rx_audio_in[8*AW +: AW];
      ret_valid = red_sel_r ? rx_valid_in[9] : rx_valid_in[8];
    end
  end

  // Distribution registered; merge and hub share one derived routing
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tx_valid_out <= {NP{1'b0}};
      tx_audio_out <= {(NP*AW){1'b0}};
      tx_side_out  <= {(NP*SW){1'b0}};
    end
    else
    begin
      for (k = 0; k < NP; k = k + 1)
      begin
        tx_side_out[k*SW +: SW] <= mrg_side;
        if (eff_preset == `PRESET_B && k < 9)
        begin
          tx_audio_out[k*AW +: AW] <= ret_audio;
          tx_valid_out[k]          <= ret_valid;
        end
        else if (eff_preset == `PRESET_C && k < 7)
        begin
          tx_audio_out[k*AW +: AW] <= ret_audio;
          tx_valid_out[k]          <= ret_valid;
        end
        else if (eff_preset == `PRESET_C && k == 8 + red_sel_r)
        begin
          tx_audio_out[k*AW +: AW] <= mrg_audio;
          tx_valid_out[k]          <= mrg_any;
        end
        else if (eff_preset == `PRESET_C && k > 7)
        begin
          // Backup port stays quiet to avoid a loop
          tx_audio_out[k*AW +: AW] <= {AW{1'b0}};
          tx_valid_out[k]          <= 1'b0;
        end
        else
        begin
          tx_audio_out[k*AW +: AW] <= mrg_audio;
          tx_valid_out[k]          <= mrg_any;
        end
      end
    end
  end

  // Merged audio buffered for the network uplink
  stream_fifo #(
    .WIDTH (AW),
    .DEPTH (`FIFO_DEPTH),
    .AW    (FAW)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (mrg_any),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (mrg_audio),
    .out_valid_out (mrg_valid_out),
    .out_ready_in  (mrg_ready_in),
    .out_data_out  (mrg_audio_out),
    .level_out     (fifo_level)
  );
  // Full buffer drops samples; stall tells the source to hold
  assign mrg_stall_out = mrg_any & ~fifo_in_ready;

  // Avalon slave: one wait cycle, answer on the second
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r & avs_read)
      begin
        case (avs_address)
          `ADDR_CTRL:       avs_readdata <= {31'h0000_0000, manual};
          `ADDR_STATUS:     avs_readdata <= {14'h0000, rx_valid_in, 4'h0, red_sel_r,
                                             manual, preset_r};
          `ADDR_FIFO_LEVEL: avs_readdata <= {27'h000_0000, fifo_level};
          `ADDR_SIDE_DATA:  avs_readdata <= {24'h00_0000, mrg_side};
          default:          avs_readdata <= 32'h0000_0000;
        endcase
      end
      // Mode bit writes are ignored: only the controller sets the mode
    end
  end
endmodule // stream_merge_router

// Parameterised synchronous FIFO with valid/ready on both sides
module stream_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             ref_clk_in,
  input  wire             nrst_in,
  // Fill side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  // Fill level
  output wire [AW:0]      level_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;
  assign in_ready_out  = (cnt_r != DEPTH[AW:0]);
  assign out_valid_out = (cnt_r != {(AW+1){1'b0}});
  assign out_data_out  = mem[rp_r];
  assign level_out     = cnt_r;
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;
  always @(posedge ref_clk_in)
  begin
    if (push)
      mem[wp_r] <= in_data_in;
  end
  always @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // stream_fifo

// [hw/stream_merge_consts.vh]
// Constants for the ten-port stream merge router
`ifndef STREAM_MERGE_CONSTS_VH
`define STREAM_MERGE_CONSTS_VH
`define PRESET_A          2'h0
`define PRESET_B          2'h1
`define PRESET_C          2'h2
`define PRESET_RST        2'h0
`define ADDR_CTRL         4'h0
`define ADDR_STATUS       4'h1
`define ADDR_FIFO_LEVEL   4'h2
`define ADDR_SIDE_DATA    4'h3
`define CTRL_MANUAL_BIT   0
`define CTRL_ADV_BIT      1
`define STAT_PRESET_LSB   0
`define STAT_MANUAL_BIT   2
`define STAT_RED_SEL_BIT  3
`define STAT_VALID_LSB    8
`define BTN_DEBOUNCE_NS   1000
`define BTN_DEBOUNCE_CYC  ((`BTN_DEBOUNCE_NS + 9) / 10)
`define FIFO_DEPTH        16
`endif

// [hw/stream_fifo.v]
// Intentionally empty: the stream buffer sits with the router logic

// [dv/router_chk.sv]
// Concurrent checks on the router's stream and bus ports
`timescale 1ns/1ps
module router_chk #(
  parameter NP = 10,
  parameter AW = 24,
  parameter SW = 8
) (
  // Clock, reset, mode
  input wire logic             ref_clk_in,
  input wire logic             nrst_in,
  input wire logic             manual_mode_in,
  // Streams
  input wire logic [NP-1:0]    rx_valid_in,
  input wire logic [NP*AW-1:0] rx_audio_in,
  input wire logic [NP*SW-1:0] rx_side_in,
  input wire logic [NP-1:0]    tx_valid_out,
  input wire logic [NP*AW-1:0] tx_audio_out,
  input wire logic [NP*SW-1:0] tx_side_out,
  // Bus
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic             avs_waitrequest
);
  logic [AW-1:0] ma, m9, m8;
  logic [SW-1:0] sd;
  wire  [AW-1:0] t1  = tx_audio_out[0+:AW];
  wire  [AW-1:0] t8  = tx_audio_out[7*AW+:AW];
  wire  [AW-1:0] t10 = tx_audio_out[9*AW+:AW];
  wire  [AW-1:0] r9  = rx_audio_in[8*AW+:AW];
  wire  [AW-1:0] r10 = rx_audio_in[9*AW+:AW];
  wire           rq  = avs_read || avs_write;

  // Reference merges over valid ports
  always_comb
  begin
    ma = '0;
    m9 = '0;
    m8 = '0;
    sd = '0;
    for (int k = 0; k < NP; k++)
      if (rx_valid_in[k])
      begin
        ma |= rx_audio_in[k*AW+:AW];
        sd |= rx_side_in[k*SW+:SW];
        if (k < 9) m9 |= rx_audio_in[k*AW+:AW];
        if (k < 8) m8 |= rx_audio_in[k*AW+:AW];
      end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_auto; !manual_mode_in |=> tx_audio_out == {NP{$past(ma)}}; endproperty
  a_auto: assert property (p_auto) else $error("auto audio wrong");
  property p_avld; !manual_mode_in && |rx_valid_in |=> &tx_valid_out; endproperty
  a_avld: assert property (p_avld) else $error("auto valid wrong");
  property p_side; 1'b1 |=> tx_side_out[8*SW-1:0] == {8{$past(sd)}}; endproperty
  a_side: assert property (p_side) else $error("side data wrong");
  property p_p8;
    manual_mode_in |=> t8 == $past(ma) || t8 == $past(r10) || t8 == $past(m8);
  endproperty
  a_p8: assert property (p_p8) else $error("port 8 audio wrong");
  property p_p10;
    manual_mode_in |=> t10 == $past(ma) || t10 == $past(m9) || t10 == $past(m8) || t10 == '0;
  endproperty
  a_p10: assert property (p_p10) else $error("port 10 audio wrong");
  property p_p1;
    manual_mode_in |=> t1 == $past(ma) || t1 == $past(r10) || t1 == $past(r9);
  endproperty
  a_p1: assert property (p_p1) else $error("port 1 audio wrong");
  property p_rq; rq && !$past(rq) |-> avs_waitrequest; endproperty
  a_rq: assert property (p_rq) else $error("no wait cycle");
  property p_ack; rq && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("wait too long");
endmodule // router_chk

bind stream_merge_router router_chk #(.NP(NP), .AW(AW), .SW(SW)) router_chk_inst (.*);

// [dv/merge_sink.sv]
// Drain model for the merged stream, with stall control
`timescale 1ns/1ps
module merge_sink (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  // Stream
  input  wire logic       hold_in,
  input  wire logic       valid_in,
  output logic            ready_out,
  output logic [7:0]      pops_out
);
  always @(posedge ref_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      ready_out <= 1'b0;
      pops_out  <= 8'h00;
    end
    else
    begin
      ready_out <= !hold_in;
      if (valid_in && ready_out) pops_out <= pops_out + 8'h01;
    end
endmodule // merge_sink

// [dv/ten_port_stream_merge_router_test.sv]
// Directed bench for the ten-port stream merge router
`timescale 1ns/1ps
module ten_port_stream_merge_router_test;
  logic         ref_clk_in, nrst_in, manual_mode_in, preset_btn_in, hold;
  logic [9:0]   rx_valid_in, tx_valid_out;
  logic [239:0] rx_audio_in, tx_audio_out;
  logic [79:0]  rx_side_in, tx_side_out;
  logic         mrg_valid_out, mrg_ready_in, mrg_stall_out;
  logic [23:0]  mrg_audio_out;
  logic [3:0]   avs_address;
  logic         avs_read, avs_write, avs_waitrequest;
  logic [31:0]  avs_writedata, avs_readdata, d;
  logic [7:0]   pops;
  int           n_mismatch, samples_checked;

  stream_merge_router stream_merge_router_inst (.*);
  merge_sink merge_sink_inst (.ref_clk_in, .nrst_in, .hold_in(hold), .valid_in(mrg_valid_out),
                              .ready_out(mrg_ready_in), .pops_out(pops));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      n_mismatch++;
    end
  endtask

  // One wait cycle is expected, but none is assumed
  task bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge ref_clk_in);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    @(posedge ref_clk_in iff avs_waitrequest === 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task ports(input int lo, input int hi, input logic [23:0] e);
    for (int k = lo; k <= hi; k++) check("tx_audio", tx_audio_out[k*24+:24], e);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task conclude;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    cyc(5000);
    n_mismatch++;
    conclude;
  end

  initial
  begin
    {nrst_in, manual_mode_in, preset_btn_in, avs_read, avs_write} = 5'h00;
    {avs_address, avs_writedata, rx_valid_in} = '0;
    hold = 1'b1;
    for (int k = 0; k < 10; k++)
    begin
      rx_audio_in[k*24+:24] = 24'h00_0001 << k;
      rx_side_in[k*8+:8] = 8'h01 << (k % 8);
    end
    cyc(4);
    nrst_in <= 1'b1;
    bus(0, 4'h1, 0, d); check("status", d, 32'h0000_0000);
    bus(0, 4'hf, 0, d); check("unmapped", d, 32'h0000_0000);
    rx_valid_in <= 10'h3ff;
    cyc(30);
    bus(0, 4'h2, 0, d); check("level", d, 32'h0000_0010);
    check("stall", mrg_stall_out, 1);
    check("mrg_valid", mrg_valid_out, 1);
    check("mrg_audio", mrg_audio_out, 24'h00_03ff);
    ports(0, 9, 24'h00_03ff);
    bus(0, 4'h3, 0, d); check("side", d, 32'h0000_00ff);
    rx_valid_in <= 10'h000;
    hold <= 1'b0;
    cyc(30);
    bus(0, 4'h2, 0, d); check("level", d, 32'h0000_0000);
    check("pops", pops >= 8'h10, 1);
    rx_valid_in <= 10'h3ff;
    manual_mode_in <= 1'b1;
    cyc(3);
    ports(0, 9, 24'h00_03ff);
    bus(1, 4'h0, 32'h0000_0002, d);
    bus(0, 4'h1, 0, d); check("status", d[3:0], 4'h5);
    cyc(3);
    ports(9, 9, 24'h00_01ff);
    ports(0, 8, 24'h00_0200);
    check("side", tx_side_out[79:72], 8'hff);
    bus(1, 4'h0, 32'h0000_0002, d);
    bus(0, 4'h1, 0, d); check("status", d[3:0], 4'h6);
    cyc(3);
    ports(7, 8, 24'h00_00ff);
    check("spare", tx_valid_out[9], 0);
    ports(0, 6, 24'h00_0100);
    check("side", tx_side_out[7:0], 8'hff);
    rx_valid_in[8] <= 1'b0;
    cyc(3);
    bus(0, 4'h1, 0, d); check("red_sel", d[3], 1);
    check("rx_valid", d[17:8], 10'h2ff);
    ports(0, 6, 24'h00_0200);
    ports(9, 9, 24'h00_00ff);
    check("backup", tx_valid_out[8], 0);
    manual_mode_in <= 1'b0;
    cyc(3);
    ports(0, 9, 24'h00_02ff);
    preset_btn_in <= 1'b1;
    cyc(130);
    preset_btn_in <= 1'b0;
    cyc(130);
    bus(0, 4'h1, 0, d); check("preset", d[1:0], 2'h0);
    conclude;
  end
endmodule // ten_port_stream_merge_router_test
